//--- design/lofc_top.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lofc_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] stream_mode,
	input wire logic pix_clk,
	input wire logic pix_de,
	input wire logic pix_hs,
	input wire logic pix_vs,
	input wire logic [23:0] pix_a,
	input wire logic [23:0] pix_b,
	output logic chan_a_en,
	output logic chan_b_en,
	output logic [2:0] link_mode,
	output logic chan_a_fourth_lane_pair,
	output logic chan_b_fourth_lane_pair,
	output logic chan_a_de,
	output logic chan_a_hs,
	output logic chan_a_vs,
	output logic chan_b_de,
	output logic chan_b_hs,
	output logic chan_b_vs,
	output logic [23:0] chan_a_data,
	output logic [23:0] chan_b_data,
	output logic chan_a_common_mode_low,
	output logic chan_b_common_mode_low,
	output logic [1:0] chan_a_output_swing,
	output logic [1:0] chan_b_output_swing
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] fmt_r;
	logic [7:0] lvl_r;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fmt_r <= lofc_pkg::FMT_RESET;
			lvl_r <= lofc_pkg::LVL_RESET;
		end else if (reg_wr) begin
			if (reg_addr == lofc_pkg::FMT_OFFSET) begin
				fmt_r <= reg_wdata;
			end
			if (reg_addr == lofc_pkg::LVL_OFFSET) begin
				lvl_r <= reg_wdata & lofc_pkg::LVL_MASK;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && reg_addr == lofc_pkg::FMT_OFFSET) begin
			reg_rdata <= fmt_r;
		end else if (reg_rd && reg_addr == lofc_pkg::LVL_OFFSET) begin
			reg_rdata <= lvl_r;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [1:0] mode_s1_r;
	logic [1:0] mode_s2_r;
	logic [51:0] vid_s1_r;
	logic [51:0] vid_s2_r;
	logic [51:0] vid_cap_r;
	logic pclk_s1_r;
	logic pclk_s2_r;
	logic pclk_d_r;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_s1_r <= 2'h0;
			mode_s2_r <= 2'h0;
			vid_s1_r <= 52'h0;
			vid_s2_r <= 52'h0;
			pclk_s1_r <= 1'b0;
			pclk_s2_r <= 1'b0;
			pclk_d_r <= 1'b0;
		end else begin
			mode_s1_r <= stream_mode;
			mode_s2_r <= mode_s1_r;
			vid_s1_r <= {pix_de, pix_hs, pix_vs, pix_a, pix_b, 1'b0};
			vid_s2_r <= vid_s1_r;
			pclk_s1_r <= pix_clk;
			pclk_s2_r <= pclk_s1_r;
			pclk_d_r <= pclk_s2_r;
		end
	end
	// Capture video on the rising edge of the pixel clock
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			vid_cap_r <= 52'h0;
		end else if (pclk_s2_r && !pclk_d_r) begin
			vid_cap_r <= vid_s2_r;
		end
	end
	// ----------------------------------------
	// Link configuration
	// ----------------------------------------
	lofc_pkg::lofc_link_t link_nxt;
	always_comb begin
		if (fmt_r[lofc_pkg::LINK_BIT]) begin
			link_nxt = lofc_pkg::LOFC_SINGLE;
		end else if (mode_s2_r == lofc_pkg::STREAM_TWO) begin
			link_nxt = lofc_pkg::LOFC_TWO_SINGLE;
		end else begin
			link_nxt = lofc_pkg::LOFC_DUAL;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			link_mode <= lofc_pkg::LOFC_SINGLE;
			chan_a_en <= 1'b1;
			chan_b_en <= 1'b0;
		end else begin
			link_mode <= link_nxt;
			chan_a_en <= 1'b1;
			chan_b_en <= !fmt_r[lofc_pkg::LINK_BIT];
		end
	end
	// ----------------------------------------
	// Lane four and colour format
	// ----------------------------------------
	function automatic logic [23:0] lofc_fmt(input logic [23:0] px,
		input logic wide, input logic lsb);
		logic [23:0] o;
		o = px;
		if (!wide && lsb) begin
			o = {px[23:18], 2'h0, px[15:10], 2'h0, px[7:2], 2'h0};
		end
		return o;
	endfunction : lofc_fmt
	logic a_wide;
	logic b_wide;
	logic a_lsb;
	logic b_lsb;
	assign a_wide = fmt_r[lofc_pkg::A_WIDE_BIT];
	assign b_wide = fmt_r[lofc_pkg::B_WIDE_BIT];
	assign a_lsb = fmt_r[lofc_pkg::A_LSB_BIT];
	assign b_lsb = fmt_r[lofc_pkg::B_LSB_BIT];
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			chan_a_fourth_lane_pair <= 1'b0;
			chan_b_fourth_lane_pair <= 1'b0;
			chan_a_data <= 24'h0;
			chan_b_data <= 24'h0;
		end else begin
			chan_a_fourth_lane_pair <= a_wide;
			chan_b_fourth_lane_pair <= b_wide && !fmt_r[lofc_pkg::LINK_BIT];
			chan_a_data <= lofc_fmt(vid_cap_r[48:25], a_wide, a_lsb);
			chan_b_data <= fmt_r[lofc_pkg::LINK_BIT] ? 24'h0 :
				lofc_fmt(vid_cap_r[24:1], b_wide, b_lsb);
		end
	end
	// ----------------------------------------
	// Control polarity
	// ----------------------------------------
	logic de_o;
	logic hs_o;
	logic vs_o;
	assign de_o = vid_cap_r[51] ^ fmt_r[lofc_pkg::DE_INV_BIT];
	assign hs_o = vid_cap_r[50] ^ fmt_r[lofc_pkg::HS_INV_BIT];
	assign vs_o = vid_cap_r[49] ^ fmt_r[lofc_pkg::VS_INV_BIT];
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			chan_a_de <= 1'b0;
			chan_a_hs <= 1'b1;
			chan_a_vs <= 1'b1;
			chan_b_de <= 1'b0;
			chan_b_hs <= 1'b1;
			chan_b_vs <= 1'b1;
		end else begin
			chan_a_de <= de_o;
			chan_a_hs <= hs_o;
			chan_a_vs <= vs_o;
			chan_b_de <= de_o;
			chan_b_hs <= hs_o;
			chan_b_vs <= vs_o;
		end
	end
	// ----------------------------------------
	// Output level
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			chan_a_common_mode_low <= 1'b0;
			chan_b_common_mode_low <= 1'b0;
			chan_a_output_swing <= 2'h1;
			chan_b_output_swing <= 2'h1;
		end else begin
			chan_a_common_mode_low <= lvl_r[6];
			chan_b_common_mode_low <= lvl_r[4];
			chan_a_output_swing <= lvl_r[3:2];
			chan_b_output_swing <= lvl_r[1:0];
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_de_pol;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_a_de == ($past(vid_cap_r[51]) ^ $past(fmt_r[7]));
	endproperty
	a_de_pol: assert property (p_de_pol) else $error("de polarity");
	property p_hs_pol;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_a_hs == ($past(vid_cap_r[50]) ^ $past(fmt_r[6]));
	endproperty
	a_hs_pol: assert property (p_hs_pol) else $error("hs polarity");
	property p_vs_pol;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_b_vs == ($past(vid_cap_r[49]) ^ $past(fmt_r[5]));
	endproperty
	a_vs_pol: assert property (p_vs_pol) else $error("vs polarity");
	property p_single;
		@(posedge clk) disable iff (!rst_b)
		fmt_r[4] |=> !chan_b_en && chan_a_en && link_mode == 3'h1;
	endproperty
	a_single: assert property (p_single) else $error("single link");
	property p_dual;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[4] && mode_s2_r != 2'h2 |=> chan_b_en && link_mode == 3'h2;
	endproperty
	a_dual: assert property (p_dual) else $error("dual link");
	property p_two;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[4] && mode_s2_r == 2'h2 |=> link_mode == 3'h4;
	endproperty
	a_two: assert property (p_two) else $error("two single");
	property p_lane_a;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_a_fourth_lane_pair == $past(fmt_r[3]);
	endproperty
	a_lane_a: assert property (p_lane_a) else $error("lane a");
	property p_drop;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[3] && fmt_r[1] |=> chan_a_data[1:0] == 2'h0;
	endproperty
	a_drop: assert property (p_drop) else $error("lsb drop");
	property p_same;
		@(posedge clk) disable iff (!rst_b)
		chan_b_en |-> chan_a_hs == chan_b_hs && chan_a_de == chan_b_de;
	endproperty
	a_same: assert property (p_same) else $error("polarity match");
	property p_de_pol_b;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_b_de == ($past(vid_cap_r[51]) ^ $past(fmt_r[7]));
	endproperty
	a_de_pol_b: assert property (p_de_pol_b) else $error("de b");
	property p_hs_pol_b;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_b_hs == ($past(vid_cap_r[50]) ^ $past(fmt_r[6]));
	endproperty
	a_hs_pol_b: assert property (p_hs_pol_b) else $error("hs b");
	property p_vs_pol_a;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_a_vs == ($past(vid_cap_r[49]) ^ $past(fmt_r[5]));
	endproperty
	a_vs_pol_a: assert property (p_vs_pol_a) else $error("vs a");
	property p_a_on;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_a_en;
	endproperty
	a_a_on: assert property (p_a_on) else $error("channel a on");
	property p_b_off;
		@(posedge clk) disable iff (!rst_b)
		fmt_r[4] |=> chan_b_data == 24'h0 && !chan_b_fourth_lane_pair;
	endproperty
	a_b_off: assert property (p_b_off) else $error("channel b off");
	property p_dual_src;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[4] && mode_s2_r == 2'h1 |=> link_mode == 3'h2;
	endproperty
	a_dual_src: assert property (p_dual_src) else $error("dual mode");
	property p_two_en;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[4] && mode_s2_r == 2'h2 |=> chan_a_en && chan_b_en;
	endproperty
	a_two_en: assert property (p_two_en) else $error("two enables");
	property p_lane_a_off;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[3] |=> !chan_a_fourth_lane_pair;
	endproperty
	a_lane_a_off: assert property (p_lane_a_off) else $error("lane a off");
	property p_lane_b;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_b_fourth_lane_pair ==
			($past(fmt_r[2]) && !$past(fmt_r[4]));
	endproperty
	a_lane_b: assert property (p_lane_b) else $error("lane b");
	property p_lane_b_off;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[2] |=> !chan_b_fourth_lane_pair;
	endproperty
	a_lane_b_off: assert property (p_lane_b_off) else $error("lane b off");
	property p_fmt_a;
		@(posedge clk) disable iff (!rst_b)
		fmt_r[3] |=> chan_a_data == $past(vid_cap_r[48:25]);
	endproperty
	a_fmt_a: assert property (p_fmt_a) else $error("format a");
	property p_fmt_b;
		@(posedge clk) disable iff (!rst_b)
		fmt_r[2] && !fmt_r[4] |=> chan_b_data == $past(vid_cap_r[24:1]);
	endproperty
	a_fmt_b: assert property (p_fmt_b) else $error("format b");
	property p_drop_a_hi;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[3] && fmt_r[1] |=>
			chan_a_data[9:8] == 2'h0 && chan_a_data[17:16] == 2'h0;
	endproperty
	a_drop_a_hi: assert property (p_drop_a_hi) else $error("drop a");
	property p_drop_b;
		@(posedge clk) disable iff (!rst_b)
		!fmt_r[2] && fmt_r[0] && !fmt_r[4] |=> chan_b_data[1:0] == 2'h0 &&
			chan_b_data[9:8] == 2'h0 && chan_b_data[17:16] == 2'h0;
	endproperty
	a_drop_b: assert property (p_drop_b) else $error("drop b");
	property p_same_vs;
		@(posedge clk) disable iff (!rst_b)
		chan_b_en |-> chan_a_vs == chan_b_vs;
	endproperty
	a_same_vs: assert property (p_same_vs) else $error("vs match");
	property p_cm_a;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_a_common_mode_low == $past(lvl_r[6]);
	endproperty
	a_cm_a: assert property (p_cm_a) else $error("common mode a");
	property p_cm_b;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_b_common_mode_low == $past(lvl_r[4]);
	endproperty
	a_cm_b: assert property (p_cm_b) else $error("common mode b");
	property p_swing;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> chan_a_output_swing == $past(lvl_r[3:2]) &&
			chan_b_output_swing == $past(lvl_r[1:0]);
	endproperty
	a_swing: assert property (p_swing) else $error("swing");
endmodule : lofc_top
`default_nettype wire

//--- design/lofc_pkg.sv
package lofc_pkg;
	localparam logic [7:0] FMT_OFFSET = 8'h18;
	localparam logic [7:0] LVL_OFFSET = 8'h19;
	localparam logic [7:0] FMT_RESET = 8'h70;
	localparam logic [7:0] LVL_RESET = 8'h05;
	localparam logic [7:0] LVL_MASK = 8'h5f;
	localparam int DE_INV_BIT = 7;
	localparam int HS_INV_BIT = 6;
	localparam int VS_INV_BIT = 5;
	localparam int LINK_BIT = 4;
	localparam int A_WIDE_BIT = 3;
	localparam int B_WIDE_BIT = 2;
	localparam int A_LSB_BIT = 1;
	localparam int B_LSB_BIT = 0;
	localparam logic [1:0] STREAM_TWO = 2'h2;
	typedef enum logic [2:0] {
		LOFC_SINGLE = 3'h1,
		LOFC_DUAL = 3'h2,
		LOFC_TWO_SINGLE = 3'h4
	} lofc_link_t;
endpackage : lofc_pkg

//--- tb/lofc_panel.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Receiver model: decodes active pixels
// ----------------------------------------
module lofc_panel (
	input wire logic clk,
	input wire logic en,
	input wire logic de,
	input wire logic de_inv,
	output logic active
);
	always_ff @(posedge clk) begin
		active <= en & (de ^ de_inv);
	end
endmodule : lofc_panel
`default_nettype wire

//--- tb/lofc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	error_cnt++; $display("wrong value at %0t: %h vs %h", $time, a, e); \
	end end
module lofc_top_tb_top;
	logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, pix_clk = 0;
	logic pix_de = 0, pix_hs = 0, pix_vs = 0, panel_inv = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [1:0] stream_mode = 2'h0, a_sw, b_sw;
	logic [23:0] pix_a = 24'h123457, pix_b = 24'habcdef, a_dat, b_dat;
	logic [2:0] link_mode;
	logic a_en, b_en, a_l4, b_l4, a_de, a_hs, a_vs, b_de, b_hs, b_vs;
	logic a_cm, b_cm, b_act;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	always #20 clk = ~clk;
	lofc_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .stream_mode(stream_mode), .pix_clk(pix_clk),
		.pix_de(pix_de), .pix_hs(pix_hs), .pix_vs(pix_vs), .pix_a(pix_a),
		.pix_b(pix_b), .chan_a_en(a_en), .chan_b_en(b_en),
		.link_mode(link_mode), .chan_a_fourth_lane_pair(a_l4),
		.chan_b_fourth_lane_pair(b_l4), .chan_a_de(a_de), .chan_a_hs(a_hs),
		.chan_a_vs(a_vs), .chan_b_de(b_de), .chan_b_hs(b_hs),
		.chan_b_vs(b_vs), .chan_a_data(a_dat), .chan_b_data(b_dat),
		.chan_a_common_mode_low(a_cm), .chan_b_common_mode_low(b_cm),
		.chan_a_output_swing(a_sw), .chan_b_output_swing(b_sw));
	lofc_panel rx_b (.clk(clk), .en(b_en), .de(b_de), .de_inv(panel_inv),
		.active(b_act));
	// ----------------------------------------
	// Pixel clock and run limit
	// ----------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3) pix_clk <= ~pix_clk;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		`CHK(reg_rdata, e)
	endtask : rd
	task automatic settle();
		repeat (16) @(posedge clk);
		#1;
	endtask : settle
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(8'h18, 8'h70);
		rd(8'h19, 8'h05);
		rd(8'h33, 8'h00);
		`CHK({a_en, b_en, link_mode}, 5'b10001)
		`CHK({a_l4, b_l4}, 2'b00)
	endtask : t_reset
	task automatic t_video();
		@(posedge clk);
		pix_de <= 1'b1;
		pix_hs <= 1'b1;
		settle();
		`CHK({a_de, a_hs, a_vs}, 3'b101)
		`CHK(b_dat, 24'h000000)
		@(posedge clk);
		panel_inv <= 1'b1;
		wr(8'h18, 8'h80);
		settle();
		`CHK({a_de, a_hs, a_vs, b_de, b_hs, b_vs}, 6'b010010)
		`CHK(b_act, 1'b1)
		`CHK({b_en, link_mode}, 4'b1010)
		`CHK(b_dat, pix_b)
		@(posedge clk);
		stream_mode <= 2'h1;
		settle();
		`CHK(link_mode, 3'h2)
		@(posedge clk);
		stream_mode <= 2'h2;
		settle();
		`CHK({a_en, b_en, link_mode}, 5'b11100)
	endtask : t_video
	task automatic t_width();
		wr(8'h18, 8'h6e);
		settle();
		`CHK(a_l4, 1'b1)
		`CHK(b_l4, 1'b1)
		`CHK(a_dat, pix_a)
		`CHK(b_dat, pix_b)
		// narrow with lsb format on both channels
		wr(8'h18, 8'h63);
		settle();
		`CHK({a_l4, b_l4}, 2'b00)
		`CHK(a_dat, 24'h103454)
		`CHK(b_dat, 24'ha8ccec)
	endtask : t_width
	task automatic t_level();
		// swing trim and low common mode programmed in one write
		wr(8'h19, 8'hda);
		rd(8'h19, 8'h5a);
		`CHK({a_cm, b_cm, a_sw, b_sw}, 6'b111010)
		wr(8'h1c, 8'hff);
		rd(8'h18, 8'h63);
	endtask : t_level
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_video();
		t_width();
		t_level();
		end_sim();
	end
endmodule : lofc_top_tb_top
`default_nettype wire
